// >>> test_tpc_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_tpc_top
	import tpc_pkg::*;
;
	localparam int IL = 20;
	localparam int SL = 60;
	localparam int SF = 12;
	localparam int SS = 30;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        irq_o;
	logic        thr_sel = 1'b1;
	logic        sens_sel = 1'b1;
	logic        period_sel = 1'b0;
	logic        meas_valid;
	logic [15:0] meas_count;
	logic [15:0] cnt = 16'h0800;
	logic [3:0]  lag = 4'h0;
	logic        sample_req_o;
	logic        touch_n_o;
	logic        thr_high_o;
	logic        xfer_14mhz_o;
	logic        sens_high_o;
	logic        sp_slow_o;
	logic        snap_touch_n;
	logic        snap_thr_high;
	logic        snap_xfer;
	logic [31:0] rd;
	int          miscompares = 0;
	int          n_tests = 0;

	always #5 clk_i = ~clk_i;

	tpc_top #(.INIT_LEN(IL), .START_LEN(SL), .SP_SLOW_LEN(SS), .SP_FAST_LEN(SF)) tpc_top_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .thr_sel_i(thr_sel),
		.sens_sel_i(sens_sel), .period_sel_i(period_sel), .meas_valid_i(meas_valid),
		.meas_count_i(meas_count), .sample_req_o(sample_req_o), .touch_n_o(touch_n_o),
		.thr_high_o(thr_high_o), .xfer_14mhz_o(xfer_14mhz_o), .sens_high_o(sens_high_o),
		.sp_slow_o(sp_slow_o));

	tpc_top #(.VARIANT(VAR_IND_SNAP), .INIT_LEN(IL), .START_LEN(SL)) tpc_top_snap_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
		.wb_dat_o(), .wb_ack_o(), .irq_o(), .thr_sel_i(thr_sel), .sens_sel_i(sens_sel),
		.period_sel_i(period_sel), .meas_valid_i(meas_valid), .meas_count_i(meas_count),
		.sample_req_o(), .touch_n_o(snap_touch_n), .thr_high_o(snap_thr_high),
		.xfer_14mhz_o(snap_xfer), .sens_high_o(), .sp_slow_o());

	tpc_sensor_model tpc_sensor_model_inst (.clk_i(clk_i), .rst_i(rst_i),
		.sample_req_i(sample_req_o), .count_i(cnt), .lag_i(lag),
		.meas_valid_o(meas_valid), .meas_count_o(meas_count));

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		if (n >= 50) begin
			miscompares++;
			test_done();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// Two answers are awaited: the first may still carry the previous count
	task automatic sample(input logic [15:0] v);
		int n;
		n = 0;
		@(posedge clk_i);
		cnt <= v;
		repeat (2) begin
			do begin
				@(posedge clk_i);
				n++;
			end while (meas_valid !== 1'b1 && n < 200);
		end
		if (n >= 200) begin
			miscompares++;
			test_done();
		end
		@(negedge clk_i);
	endtask : sample

	task automatic t_power();
		@(negedge clk_i);
		`CHK(touch_n_o, 1'b0)
		`CHK(snap_touch_n, 1'b1)
		`CHK(thr_high_o, 1'b0)
		repeat (IL + 6) @(posedge clk_i);
		@(negedge clk_i);
		`CHK({thr_high_o, xfer_14mhz_o}, 2'b10)
		`CHK({snap_thr_high, snap_xfer}, 2'b01)
		`CHK(sens_high_o, 1'b1)
		`CHK(sp_slow_o, 1'b0)
		wb(1'b0, ADDR_CONFIG, 32'h0);
		`CHK(rd & 32'h37, 32'h13)
		@(posedge clk_i);
		// Straps move after latching; outputs keep the latched high sensitivity, grounded sensitivity is exercised in t_rearm
		thr_sel    <= 1'b0;
		sens_sel   <= 1'b0;
		period_sel <= 1'b1;
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		`CHK({thr_high_o, sens_high_o, sp_slow_o}, 3'b110)
		`CHK(touch_n_o, 1'b0)
		$display("t_power finished");
	endtask : t_power

	task automatic t_period();
		int n;
		n = 0;
		while (sample_req_o !== 1'b1 && n < SL + 40) begin
			@(posedge clk_i);
			n++;
		end
		`CHK(n < SL + 40, 1'b1)
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (sample_req_o !== 1'b1 && n < 100);
		`CHK(n, SF)
		sample(16'h0800);
		`CHK(touch_n_o, 1'b1)
		wb(1'b0, ADDR_REF, 32'h0);
		`CHK(rd, 32'h800)
		$display("t_period finished");
	endtask : t_period

	task automatic t_touch();
		sample(16'h0700);
		`CHK(touch_n_o, 1'b0)
		`CHK(irq_o, 1'b0)
		wb(1'b0, ADDR_REF, 32'h0);
		`CHK(rd, 32'h800)
		wb(1'b0, ADDR_STATUS, 32'h0);
		`CHK(rd[0], 1'b1)
		lag <= 4'h3;
		sample(16'h0800);
		`CHK(touch_n_o, 1'b1)
		$display("t_touch finished");
	endtask : t_touch

	task automatic t_reseed();
		wb(1'b1, ADDR_MASK, 32'h4);
		sample(16'h0700);
		wb(1'b0, ADDR_STATUS, 32'h0);
		`CHK(touch_n_o, 1'b0)
		wb(1'b1, ADDR_CTRL, 32'h1);
		sample(16'h0700);
		`CHK(touch_n_o, 1'b1)
		`CHK(irq_o, 1'b1)
		wb(1'b0, ADDR_REF, 32'h0);
		`CHK(rd, 32'h700)
		wb(1'b0, ADDR_STATUS, 32'h0);
		`CHK(rd & 32'h6, 32'h6)
		@(negedge clk_i);
		`CHK(irq_o, 1'b0)
		sample(16'h0710);
		wb(1'b0, ADDR_REF, 32'h0);
		`CHK(rd, 32'h701)
		$display("t_reseed finished");
	endtask : t_reseed

	task automatic t_clamp();
		sample(16'hffff);
		wb(1'b0, ADDR_COUNT, 32'h0);
		`CHK(rd, 32'h0fff)
		wb(1'b0, ADDR_STATUS, 32'h0);
		`CHK(rd[3], 1'b1)
		wb(1'b0, 8'h3c, 32'h0);
		`CHK(rd, 32'h0)
		$display("t_clamp finished");
	endtask : t_clamp

	// Reset in mid-run: grounded straps must now be latched
	task automatic t_rearm();
		int n;
		n = 0;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		`CHK({touch_n_o, snap_touch_n, irq_o, sample_req_o}, 4'h4)
		repeat (IL + 6) @(posedge clk_i);
		@(negedge clk_i);
		`CHK({thr_high_o, xfer_14mhz_o, snap_thr_high, snap_xfer}, 4'h0)
		`CHK({sens_high_o, sp_slow_o}, 2'b01)
		while (sample_req_o !== 1'b1 && n < SL + 40) begin
			@(posedge clk_i);
			n++;
		end
		`CHK(n < SL + 40, 1'b1)
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (sample_req_o !== 1'b1 && n < 100);
		`CHK(n, SS)
		wb(1'b0, ADDR_CONFIG, 32'h0);
		`CHK(rd & 32'h37, 32'h24)
		$display("t_rearm finished");
	endtask : t_rearm

	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		test_done();
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_power();
		t_period();
		t_touch();
		t_reseed();
		t_clamp();
		t_rearm();
		test_done();
	end
endmodule : test_tpc_top
`default_nettype wire

// >>> tpc_pkg.sv
package tpc_pkg;

	localparam int CYC_PER_MS  = 100_000;
	localparam int INIT_MS     = 12;
	localparam int START_MS    = 250;
	localparam int SP_SLOW_MS  = 200;
	localparam int SP_FAST_MS  = 43;
	localparam int INIT_CYC    = INIT_MS * CYC_PER_MS;
	localparam int START_CYC   = START_MS * CYC_PER_MS;
	localparam int SP_SLOW_CYC = SP_SLOW_MS * CYC_PER_MS;
	localparam int SP_FAST_CYC = SP_FAST_MS * CYC_PER_MS;
	localparam int TIMER_W     = 32;

	localparam int COUNT_W     = 16;
	localparam logic [15:0] MAX_COUNT_DEF = 16'h0fff;
	localparam int THR_SHIFT_HI = 3;
	localparam int THR_SHIFT_LO = 4;
	localparam int SENS_SHIFT   = 1;
	localparam int REL_SHIFT    = 1;
	localparam int REF_BETA     = 4;

	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK   = 8'h08;
	localparam logic [7:0] ADDR_COUNT  = 8'h0c;
	localparam logic [7:0] ADDR_REF    = 8'h10;
	localparam logic [7:0] ADDR_CONFIG = 8'h14;

	localparam int CTRL_RESEED_BIT = 0;
	localparam int EV_W            = 4;
	localparam int EV_TOUCH        = 0;
	localparam int EV_RELEASE      = 1;
	localparam int EV_RESEED       = 2;
	localparam int EV_CLAMP        = 3;
	localparam logic [EV_W-1:0] MASK_RST = 4'h0;

	localparam int STRAP_THR  = 0;
	localparam int STRAP_SENS = 1;
	localparam int STRAP_SP   = 2;

	typedef enum logic [1:0] {
		VAR_IND_SWITCH = 2'b00,
		VAR_IND_BUTTON = 2'b01,
		VAR_IND_SNAP   = 2'b10,
		VAR_SELF_CAP   = 2'b11
	} tpc_variant_t;

	typedef enum logic [1:0] {
		PH_INIT  = 2'b00,
		PH_START = 2'b01,
		PH_RUN   = 2'b10
	} tpc_phase_t;

endpackage : tpc_pkg

// >>> tpc_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
// Stand-in for the sensing front end: answers a start request lag_i + 1 cycles after taking it, ignoring requests while busy
module tpc_sensor_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        sample_req_i,
	input  wire logic [15:0] count_i,
	input  wire logic [3:0]  lag_i,
	output logic             meas_valid_o,
	output logic      [15:0] meas_count_o
);
	logic       busy_reg;
	logic [3:0] wait_reg;

	always_ff @(posedge clk_i) begin
		meas_valid_o <= 1'b0;
		// Idle data toggles so a stale count never looks valid
		meas_count_o <= ~meas_count_o;
		if (rst_i) begin
			busy_reg     <= 1'b0;
			wait_reg     <= 4'h0;
			meas_count_o <= 16'h0;
		end else if (busy_reg && wait_reg == 4'h0) begin
			busy_reg     <= 1'b0;
			meas_valid_o <= 1'b1;
			meas_count_o <= count_i;
		end else if (busy_reg) begin
			wait_reg <= wait_reg - 4'h1;
		end else if (sample_req_i) begin
			busy_reg <= 1'b1;
			wait_reg <= lag_i;
		end
	end
endmodule : tpc_sensor_model
`default_nettype wire

// >>> tpc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_sync #(
	parameter int W = 3
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d_i;
			q_reg    <= meta_reg;
		end
	end

	assign q_o = q_reg;
endmodule : tpc_sync
`default_nettype wire

// >>> tpc_top.sv
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module tpc_top
	import tpc_pkg::*;
#(
	parameter tpc_variant_t       VARIANT     = VAR_SELF_CAP,
	parameter logic [COUNT_W-1:0] MAX_COUNT   = MAX_COUNT_DEF,
	parameter int                 INIT_LEN    = INIT_CYC,
	parameter int                 START_LEN   = START_CYC,
	parameter int                 SP_SLOW_LEN = SP_SLOW_CYC,
	parameter int                 SP_FAST_LEN = SP_FAST_CYC
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [ADDR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	output logic                    irq_o,
	input  wire logic               thr_sel_i,
	input  wire logic               sens_sel_i,
	input  wire logic               period_sel_i,
	input  wire logic               meas_valid_i,
	input  wire logic [COUNT_W-1:0] meas_count_i,
	output logic                    sample_req_o,
	output logic                    touch_n_o,
	output logic                    thr_high_o,
	output logic                    xfer_14mhz_o,
	output logic                    sens_high_o,
	output logic                    sp_slow_o
);
	// Only self-capacitive parts power up showing a touch
	localparam logic POR_TOUCH = (VARIANT == VAR_SELF_CAP);

	function automatic logic [COUNT_W-1:0] thr_of(input logic [COUNT_W-1:0] ref_v,
			input logic thr_hi, input logic sens_hi);
		logic [COUNT_W-1:0] t;
		t = thr_hi ? (ref_v >> THR_SHIFT_HI) : (ref_v >> THR_SHIFT_LO);
		thr_of = sens_hi ? (t >> SENS_SHIFT) : t;
	endfunction : thr_of

	logic [2:0] strap_sync;
	tpc_sync #(.W(3)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({period_sel_i, sens_sel_i, thr_sel_i}),
		.q_o   (strap_sync)
	);

	// Phase, straps and sample timer
	tpc_phase_t         phase_reg, phase_next;
	logic [TIMER_W-1:0] timer_reg, timer_next;
	logic [TIMER_W-1:0] sp_cnt_reg, sp_cnt_next;
	logic [2:0]         strap_reg, strap_next;
	logic               thr_high_reg, thr_high_next;
	logic               xfer_reg, xfer_next;
	logic               sens_reg, sens_next;
	logic               sp_slow_reg, sp_slow_next;
	logic               req_reg, req_next;
	logic               enter_run;

	always_comb begin
		phase_next    = phase_reg;
		timer_next    = timer_reg;
		sp_cnt_next   = sp_cnt_reg;
		strap_next    = strap_reg;
		thr_high_next = thr_high_reg;
		xfer_next     = xfer_reg;
		sens_next     = sens_reg;
		sp_slow_next  = sp_slow_reg;
		req_next      = 1'b0;
		enter_run     = 1'b0;
		unique case (phase_reg)
			PH_INIT: begin
				if (timer_reg == '0) begin
					strap_next    = strap_sync;
					thr_high_next = (VARIANT != VAR_IND_SNAP) && strap_sync[STRAP_THR];
					xfer_next     = (VARIANT == VAR_IND_SNAP) && strap_sync[STRAP_THR];
					sens_next     = strap_sync[STRAP_SENS];
					sp_slow_next  = strap_sync[STRAP_SP];
					timer_next    = TIMER_W'(START_LEN - INIT_LEN - 1);
					phase_next    = PH_START;
				end else begin
					timer_next = timer_reg - 1'b1;
				end
			end
			PH_START: begin
				if (timer_reg == '0) begin
					phase_next  = PH_RUN;
					enter_run   = 1'b1;
					sp_cnt_next = '0;
				end else begin
					timer_next = timer_reg - 1'b1;
				end
			end
			PH_RUN: begin
				if (sp_cnt_reg == '0) begin
					req_next    = 1'b1;
					sp_cnt_next = sp_slow_reg ? TIMER_W'(SP_SLOW_LEN - 1)
						: TIMER_W'(SP_FAST_LEN - 1);
				end else begin
					sp_cnt_next = sp_cnt_reg - 1'b1;
				end
			end
			default: phase_next = PH_INIT;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_reg    <= PH_INIT;
			timer_reg    <= TIMER_W'(INIT_LEN - 1);
			sp_cnt_reg   <= '0;
			strap_reg    <= '0;
			thr_high_reg <= 1'b0;
			xfer_reg     <= 1'b0;
			sens_reg     <= 1'b0;
			sp_slow_reg  <= 1'b0;
			req_reg      <= 1'b0;
		end else begin
			phase_reg    <= phase_next;
			timer_reg    <= timer_next;
			sp_cnt_reg   <= sp_cnt_next;
			strap_reg    <= strap_next;
			thr_high_reg <= thr_high_next;
			xfer_reg     <= xfer_next;
			sens_reg     <= sens_next;
			sp_slow_reg  <= sp_slow_next;
			req_reg      <= req_next;
		end
	end

	// Detection, reference and reseed
	logic [COUNT_W-1:0] count_reg, count_next;
	logic [COUNT_W-1:0] ref_reg, ref_next;
	logic               touch_reg, touch_next;
	logic               touch_n_reg, touch_n_next;
	logic               reseed_pend_reg, reseed_pend_next;
	logic [EV_W-1:0]    ev;
	logic               sw_reseed;
	logic               sample_ev;
	logic [COUNT_W-1:0] cnt_sat, delta, thr;
	logic signed [COUNT_W:0] step;

	assign sample_ev = meas_valid_i && (phase_reg == PH_RUN);

	always_comb begin
		count_next       = count_reg;
		ref_next         = ref_reg;
		touch_next       = touch_reg;
		reseed_pend_next = reseed_pend_reg | enter_run | sw_reseed;
		ev               = '0;
		// Counts fall as the target approaches, so the delta is reference minus count
		cnt_sat = (meas_count_i > MAX_COUNT) ? MAX_COUNT : meas_count_i;
		delta   = (ref_reg > cnt_sat) ? (ref_reg - cnt_sat) : '0;
		thr     = thr_of(ref_reg, thr_high_reg, sens_reg);
		step    = ($signed({1'b0, cnt_sat}) - $signed({1'b0, ref_reg})) >>> REF_BETA;
		if (sample_ev) begin
			count_next = cnt_sat;
			ev[EV_CLAMP] = (meas_count_i > MAX_COUNT);
			if (reseed_pend_reg) begin
				ref_next         = cnt_sat;
				touch_next       = 1'b0;
				reseed_pend_next = sw_reseed;
				ev[EV_RESEED]    = 1'b1;
				ev[EV_RELEASE]   = touch_reg;
			end else if (touch_reg) begin
				if (delta < (thr >> REL_SHIFT)) begin
					touch_next     = 1'b0;
					ev[EV_RELEASE] = 1'b1;
				end
			end else if ((delta >= thr) && (thr != '0)) begin
				touch_next   = 1'b1;
				ev[EV_TOUCH] = 1'b1;
			end else begin
				ref_next = COUNT_W'($signed({1'b0, ref_reg}) + step);
			end
		end
		touch_n_next = (phase_next == PH_RUN) ? ~touch_next : ~POR_TOUCH;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg       <= '0;
			ref_reg         <= '0;
			touch_reg       <= 1'b0;
			touch_n_reg     <= ~POR_TOUCH;
			reseed_pend_reg <= 1'b0;
		end else begin
			count_reg       <= count_next;
			ref_reg         <= ref_next;
			touch_reg       <= touch_next;
			touch_n_reg     <= touch_n_next;
			reseed_pend_reg <= reseed_pend_next;
		end
	end

	// Register bus; answers every access one cycle after the strobe
	logic [31:0]     rdat_reg, rdat_next;
	logic            ack_reg, ack_next;
	logic [EV_W-1:0] status_reg, status_next;
	logic [EV_W-1:0] mask_reg, mask_next;
	logic            irq_reg, irq_next;
	logic            acc;

	always_comb begin
		acc         = wb_cyc_i && wb_stb_i && !ack_reg;
		ack_next    = acc;
		rdat_next   = rdat_reg;
		mask_next   = mask_reg;
		sw_reseed   = 1'b0;
		status_next = status_reg;
		if (acc && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == ADDR_MASK)
				mask_next = wb_dat_i[EV_W-1:0];
			if (wb_adr_i == ADDR_CTRL)
				sw_reseed = wb_dat_i[CTRL_RESEED_BIT];
		end
		if (acc && !wb_we_i) begin
			unique case (wb_adr_i)
				ADDR_CTRL:   rdat_next = {31'h0, reseed_pend_reg};
				ADDR_STATUS: rdat_next = {{(32-EV_W){1'b0}}, status_reg};
				ADDR_MASK:   rdat_next = {{(32-EV_W){1'b0}}, mask_reg};
				ADDR_COUNT:  rdat_next = {{(32-COUNT_W){1'b0}}, count_reg};
				ADDR_REF:    rdat_next = {{(32-COUNT_W){1'b0}}, ref_reg};
				ADDR_CONFIG: rdat_next = {26'h0, phase_reg, touch_reg, strap_reg};
				default:     rdat_next = 32'h0;
			endcase
			// Read clears, but an event in the same cycle survives
			if (wb_adr_i == ADDR_STATUS)
				status_next = '0;
		end
		status_next = status_next | ev;
		irq_next    = |(status_next & mask_next);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_reg   <= '0;
			ack_reg    <= 1'b0;
			status_reg <= '0;
			mask_reg   <= MASK_RST;
			irq_reg    <= 1'b0;
		end else begin
			rdat_reg   <= rdat_next;
			ack_reg    <= ack_next;
			status_reg <= status_next;
			mask_reg   <= mask_next;
			irq_reg    <= irq_next;
		end
	end

	assign wb_dat_o     = rdat_reg;
	assign wb_ack_o     = ack_reg;
	assign irq_o        = irq_reg;
	assign sample_req_o = req_reg;
	assign touch_n_o    = touch_n_reg;
	assign thr_high_o   = thr_high_reg;
	assign xfer_14mhz_o = xfer_reg;
	assign sens_high_o  = sens_reg;
	assign sp_slow_o    = sp_slow_reg;

	// Cycles since reset, saturating; only the phase-length checks read it
	logic [TIMER_W-1:0] age_reg, age_next;

	always_comb begin
		age_next = (age_reg == '1) ? age_reg : age_reg + 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			age_reg <= '0;
		end else begin
			age_reg <= age_next;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_reseed_sample;
		sample_ev && reseed_pend_reg;
	endsequence
	sequence s_touch_sample;
		sample_ev && !reseed_pend_reg && touch_reg;
	endsequence

	a_thr_level: assert property ((phase_reg == PH_RUN) |->
		thr_high_o == ((VARIANT != VAR_IND_SNAP) && strap_reg[STRAP_THR]))
		else $error("threshold level does not follow latched select");
	a_thr_low: assert property ((phase_reg == PH_RUN && !strap_reg[STRAP_THR]) |->
		!thr_high_o && !xfer_14mhz_o)
		else $error("grounded threshold select not giving low threshold");
	a_xfer_sel: assert property ((phase_reg == PH_RUN) |->
		xfer_14mhz_o == ((VARIANT == VAR_IND_SNAP) && strap_reg[STRAP_THR]))
		else $error("transfer frequency select wrong");
	a_sens_sel: assert property ((phase_reg == PH_RUN) |->
		sens_high_o == strap_reg[STRAP_SENS] && sp_slow_o == strap_reg[STRAP_SP])
		else $error("sensitivity or period select wrong");
	a_straps_held: assert property ((phase_reg != PH_INIT) |=>
		$stable(strap_reg) && $stable(sens_high_o) && $stable(thr_high_o))
		else $error("latched settings changed after init");
	a_period_gap: assert property ($rose(sample_req_o) |=> !sample_req_o [*8])
		else $error("sampling requests too close");
	a_init_end: assert property ((phase_reg == PH_INIT) == (age_reg < TIMER_W'(INIT_LEN)))
		else $error("init phase length wrong");
	a_start_end: assert property ((phase_reg == PH_RUN) == (age_reg >= TIMER_W'(START_LEN)))
		else $error("start-up phase length wrong");
	a_por_level: assert property ((phase_reg != PH_RUN) |-> touch_n_o == ~POR_TOUCH)
		else $error("power-on output level wrong");
	a_touch_out: assert property ((phase_reg == PH_RUN && $past(phase_reg) == PH_RUN) |->
		touch_n_o == !touch_reg)
		else $error("touch output does not mirror detection");
	a_clamp_max: assert property ((sample_ev && meas_count_i > MAX_COUNT) |=>
		count_reg == MAX_COUNT && status_reg[EV_CLAMP])
		else $error("count not saturated at maximum");
	a_ref_freeze: assert property (s_touch_sample |=> $stable(ref_reg))
		else $error("reference moved during touch");
	a_reseed_load: assert property (s_reseed_sample |=>
		ref_reg == count_reg && !touch_reg && touch_n_o == 1'b1)
		else $error("reseed did not load reference and clear touch");
	a_sw_reseed: assert property ((acc && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL
		&& wb_dat_i[CTRL_RESEED_BIT]) |=> reseed_pend_reg)
		else $error("software reseed not taken");
endmodule : tpc_top
`default_nettype wire
